// ---- wwd_core.sv ----
// Window watchdog core with APB registers and interrupt
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "wwd_regs.svh"

module wwd_core #(
  parameter int          TICK_CYCLES  = `WWD_TICK_CYCLES,
  parameter logic [15:0] LOW_00       = 16'(`WWD_US_TO_TICKS(`WWD_LOW_00_US)),
  parameter logic [15:0] UP_00        = 16'(`WWD_US_TO_TICKS(`WWD_UP_00_US)),
  parameter logic [15:0] LOW_01       = 16'(`WWD_US_TO_TICKS(`WWD_LOW_01_US)),
  parameter logic [15:0] UP_01        = 16'(`WWD_US_TO_TICKS(`WWD_UP_01_US)),
  parameter logic [15:0] LOW_11       = 16'(`WWD_US_TO_TICKS(`WWD_LOW_11_US)),
  parameter logic [15:0] UP_11        = 16'(`WWD_US_TO_TICKS(`WWD_UP_11_US)),
  parameter logic [15:0] DELAY_OPEN   = 16'(`WWD_US_TO_TICKS(`WWD_DELAY_OPEN_US)),
  parameter logic [15:0] DELAY_PULLUP = 16'(`WWD_US_TO_TICKS(`WWD_DELAY_PULLUP_US))
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        kick_input,
  input  wire logic        window_cap_pin,
  input  wire logic        window_strap_a,
  input  wire logic        window_strap_b,
  input  wire logic [1:0]  delay_select_pin,
  input  wire logic        fault_pin_in,
  output logic             fault_out_n,
  output logic             fault_out_oe,
  output logic             irq
);

  localparam int          TW        = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  wwd_pkg::wwd_pins_t pins_raw;
  wwd_pkg::wwd_pins_t pins;
  wwd_pkg::wwd_pins_t pins_fall;
  logic [6:0]         pins_sync_vec;
  logic [6:0]         pins_fall_vec;

  assign pins_raw = '{fault_pin:  fault_pin_in,
                      kick:       kick_input,
                      strap_b:    window_strap_b,
                      strap_a:    window_strap_a,
                      cap_fitted: window_cap_pin,
                      delay_sel:  delay_select_pin};

  wwd_pin_sync #(
    .W (7)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (pins_raw),
    .sync    (pins_sync_vec),
    .fall    (pins_fall_vec)
  );

  assign pins      = wwd_pkg::wwd_pins_t'(pins_sync_vec);
  assign pins_fall = wwd_pkg::wwd_pins_t'(pins_fall_vec);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and APB decode

  logic [15:0]               cap_window;
  logic [15:0]               cap_delay;
  logic [`WWD_IRQ_W-1:0]     irq_status;
  logic [`WWD_IRQ_W-1:0]     irq_mask;
  wwd_pkg::wwd_state_t       state;
  wwd_pkg::wwd_state_t       next_state;
  logic [15:0]               win_cnt;
  logic [15:0]               dly_cnt;
  logic [TW-1:0]             tick_cnt;

  wire        setup       = psel & ~penable;
  wire        access      = psel & penable;
  wire        hit_status  = (paddr == `WWD_OFF_STATUS);
  wire        hit_irq_st  = (paddr == `WWD_OFF_IRQ_STATUS);
  wire        hit_irq_msk = (paddr == `WWD_OFF_IRQ_MASK);
  wire        hit_cap_win = (paddr == `WWD_OFF_CAP_WINDOW);
  wire        hit_cap_dly = (paddr == `WWD_OFF_CAP_DELAY);
  wire        mapped      = hit_status | hit_irq_st | hit_irq_msk | hit_cap_win | hit_cap_dly;
  wire        wr          = access & pwrite & mapped;
  wire        rd_irq_st   = access & ~pwrite & hit_irq_st;

  wire        held        = (wwd_pkg::wwd_delay_t'(pins.delay_sel) == wwd_pkg::WWD_DLY_HELD);
  wire        disabled    = pins.strap_a & ~pins.strap_b;

  wire [31:0] status_word = {win_cnt, 10'h000, disabled, pins.fault_pin, state,
                             (state == wwd_pkg::WWD_FAULT) & held, ~fault_out_n};
  wire [31:0] read_mux    = hit_status  ? status_word :
                            hit_irq_st  ? {29'h0000000, irq_status} :
                            hit_irq_msk ? {29'h0000000, irq_mask} :
                            hit_cap_win ? {16'h0000, cap_window} :
                            hit_cap_dly ? {16'h0000, cap_delay} : 32'h00000000;

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup & ~pwrite) begin
      prdata <= read_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask   <= `WWD_IRQ_MASK_RST;
      cap_window <= `WWD_CAP_WINDOW_RST;
      cap_delay  <= `WWD_CAP_DELAY_RST;
    end else if (wr) begin
      if (hit_irq_msk) irq_mask <= pwdata[`WWD_IRQ_W-1:0];
      if (hit_cap_win) cap_window <= pwdata[15:0];
      if (hit_cap_dly) cap_delay <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Window and delay selection

  wwd_pkg::wwd_window_t factory_win;
  wwd_pkg::wwd_window_t cap_win;
  wwd_pkg::wwd_window_t win;
  logic [15:0]          delay_ticks;

  wire [1:0]            strap_code = {pins.strap_b, pins.strap_a};

  assign factory_win.lower = (strap_code == 2'h0) ? LOW_00 :
                             (strap_code == 2'h3) ? LOW_11 : LOW_01;
  assign factory_win.upper = (strap_code == 2'h0) ? UP_00 :
                             (strap_code == 2'h3) ? UP_11 : UP_01;
  assign cap_win.lower     = (strap_code == 2'h0) ? (cap_window >> 3) :
                             (strap_code == 2'h3) ? (cap_window >> 1) :
                             (cap_window >> 1) + (cap_window >> 2);
  assign cap_win.upper     = cap_window;
  assign win               = pins.cap_fitted ? cap_win : factory_win;

  assign delay_ticks = (wwd_pkg::wwd_delay_t'(pins.delay_sel) == wwd_pkg::WWD_DLY_CAP) ?
                       cap_delay :
                       (wwd_pkg::wwd_delay_t'(pins.delay_sel) == wwd_pkg::WWD_DLY_PULLUP) ?
                       DELAY_PULLUP : DELAY_OPEN;

  ////////////////////////////////////////////////////////////////////////////////
  // Window timing and fault sequencing

  wire tick       = (tick_cnt == TICK_LAST);
  wire running    = (state == wwd_pkg::WWD_RUN);
  wire kick_fall  = pins_fall.kick;
  wire early_ev   = running & kick_fall & (win_cnt < win.lower);
  wire timeout_ev = running & (win_cnt >= win.upper);
  wire good_kick  = running & kick_fall & ~early_ev & ~timeout_ev;
  wire dly_done   = (state == wwd_pkg::WWD_FAULT) & ~held & (dly_cnt >= delay_ticks);
  wire restart    = good_kick | dly_done | (state != next_state);

  always_comb begin
    next_state = state;
    case (state)
      wwd_pkg::WWD_RUN: begin
        if (disabled) next_state = wwd_pkg::WWD_OFF;
        else if (early_ev | timeout_ev) next_state = wwd_pkg::WWD_FAULT;
      end
      wwd_pkg::WWD_FAULT: begin
        if (dly_done) next_state = wwd_pkg::WWD_RUN;
      end
      wwd_pkg::WWD_OFF: begin
        if (!disabled) next_state = wwd_pkg::WWD_RUN;
      end
      default: next_state = wwd_pkg::WWD_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= wwd_pkg::WWD_RUN;
      fault_out_n <= 1'b1;
    end else begin
      state       <= next_state;
      fault_out_n <= (next_state != wwd_pkg::WWD_FAULT);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
      win_cnt  <= 16'h0000;
      dly_cnt  <= 16'h0000;
    end else if (restart) begin
      tick_cnt <= '0;
      win_cnt  <= 16'h0000;
      dly_cnt  <= 16'h0000;
    end else begin
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
      if (tick && running && win_cnt != 16'hFFFF) win_cnt <= win_cnt + 16'h0001;
      if (tick && !running && dly_cnt != 16'hFFFF) dly_cnt <= dly_cnt + 16'h0001;
    end
  end

  assign fault_out_oe = ~fault_out_n;

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status, read to clear, set wins

  wire [`WWD_IRQ_W-1:0] irq_set   = {dly_done, early_ev, timeout_ev & ~early_ev};
  wire [`WWD_IRQ_W-1:0] irq_clear = rd_irq_st ? prdata[`WWD_IRQ_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_set;
    end
  end

  assign irq = |(irq_status & irq_mask);

endmodule // wwd_core

`default_nettype wire

// ---- wwd_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the window watchdog
`ifndef WWD_REGS_SVH
`define WWD_REGS_SVH

`define WWD_OFF_STATUS       12'h000
`define WWD_OFF_IRQ_STATUS   12'h004
`define WWD_OFF_IRQ_MASK     12'h008
`define WWD_OFF_CAP_WINDOW   12'h00C
`define WWD_OFF_CAP_DELAY    12'h010

`define WWD_IRQ_TIMEOUT      0
`define WWD_IRQ_EARLY        1
`define WWD_IRQ_RELEASE      2
`define WWD_IRQ_W            3

`define WWD_ST_FAULT         0
`define WWD_ST_LATCHED       1
`define WWD_ST_STATE_LO      2
`define WWD_ST_STATE_HI      3
`define WWD_ST_PIN           4
`define WWD_ST_DISABLED      5
`define WWD_ST_CNT_LO        16

`define WWD_CAP_WINDOW_RST   16'h3E80
`define WWD_CAP_DELAY_RST    16'h07D0
`define WWD_IRQ_MASK_RST     3'h0

`define WWD_CLK_PERIOD_NS    25
`define WWD_TICK_NS          100000
`define WWD_TICK_CYCLES      (`WWD_TICK_NS / `WWD_CLK_PERIOD_NS)
`define WWD_US_TO_TICKS(t)   (((t) * 1000) / `WWD_TICK_NS)

`define WWD_LOW_00_US        25900
`define WWD_UP_00_US         46800
`define WWD_LOW_01_US        1200000
`define WWD_UP_01_US         1600000
`define WWD_LOW_11_US        800000
`define WWD_UP_11_US         1600000
`define WWD_DELAY_OPEN_US    200000
`define WWD_DELAY_PULLUP_US  10000

`endif

// ---- wwd_pkg.sv ----
// Types shared by the window watchdog files
package wwd_pkg;

  typedef enum logic [1:0] {
    WWD_RUN,
    WWD_FAULT,
    WWD_OFF
  } wwd_state_t;

  typedef enum logic [1:0] {
    WWD_DLY_OPEN,
    WWD_DLY_PULLUP,
    WWD_DLY_CAP,
    WWD_DLY_HELD
  } wwd_delay_t;

  typedef struct packed {
    logic       fault_pin;
    logic       kick;
    logic       strap_b;
    logic       strap_a;
    logic       cap_fitted;
    logic [1:0] delay_sel;
  } wwd_pins_t;

  typedef struct packed {
    logic [15:0] lower;
    logic [15:0] upper;
  } wwd_window_t;

endpackage

// ---- wwd_pin_sync.sv ----
// Two-stage pin synchroniser with falling-edge detect per bit
`timescale 1ns/1ps
`default_nettype none

module wwd_pin_sync #(
  parameter int W = 7
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] sync,
  output logic      [W-1:0] fall
);

  logic [W-1:0] meta;
  logic [W-1:0] prev;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta[i] <= 1'b0;
          sync[i] <= 1'b0;
          prev[i] <= 1'b0;
        end else begin
          meta[i] <= raw[i];
          sync[i] <= meta[i];
          prev[i] <= sync[i];
        end
      end
      assign fall[i] = prev[i] & ~sync[i];
    end
  endgenerate

endmodule // wwd_pin_sync

`default_nettype wire

// ---- wwd_core_monitor.sv ----
// Port checker for the window watchdog core
`timescale 1ns/1ps
`default_nettype none
module wwd_core_monitor #(
  parameter int          TICK_CYCLES = 4000,
  parameter logic [15:0] DELAY_OPEN  = 16'h07D0
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        window_strap_a,
  input wire logic        window_strap_b,
  input wire logic [1:0]  delay_select_pin,
  input wire logic        fault_out_n,
  input wire logic        fault_out_oe,
  input wire logic        irq
);
  localparam int LMIN = (int'(DELAY_OPEN) - 1) * TICK_CYCLES;
  localparam int LMAX = (int'(DELAY_OPEN) + 2) * TICK_CYCLES;
  logic [31:0] lowcnt;
  wire logic   acc = psel && penable;
  wire logic   mapped = paddr[11:5] == 7'h00 && paddr[1:0] == 2'h0 && paddr[4:2] <= 3'h4;
  wire logic   off = window_strap_a && !window_strap_b;
  wire logic   len_ok = int'(lowcnt) >= LMIN && int'(lowcnt) <= LMAX;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lowcnt <= 32'h0;
    else lowcnt <= fault_out_n ? 32'h0 : lowcnt + 32'h1;
  end
  a_oe_mirror: assert property (fault_out_oe == !fault_out_n) else $error("oe wrong");
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (acc && !mapped |-> pslverr) else $error("no slverr");
  a_err_mapped: assert property (acc && mapped |-> !pslverr) else $error("bad slverr");
  a_reset_idle: assert property ($rose(presetn) |-> fault_out_n && !irq) else $error("reset");
  a_fault_len: assert property ($rose(fault_out_n) && delay_select_pin == 2'h0
    |-> len_ok) else $error("delay length");
  a_latch_hold: assert property (!fault_out_n && delay_select_pin == 2'h3
    |=> !fault_out_n) else $error("latch released");
  a_off_quiet: assert property ((off && fault_out_n) [*5] |=> fault_out_n)
    else $error("fault while off");
  c_fault: cover property ($fell(fault_out_n));
  c_release: cover property ($rose(fault_out_n));
  c_irq: cover property ($rose(irq));
endmodule // wwd_core_monitor
bind wwd_core wwd_core_monitor #(.TICK_CYCLES(TICK_CYCLES), .DELAY_OPEN(DELAY_OPEN))
  wwd_core_monitor_i (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
  .window_strap_a, .window_strap_b, .delay_select_pin, .fault_out_n, .fault_out_oe, .irq);
`default_nettype wire

// ---- wwd_mcu.sv ----
// Controller model that kicks the watchdog at a set spacing
`timescale 1ns/1ps
`default_nettype none
module wwd_mcu (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       en,
  input  wire logic [7:0] gap,
  output logic            kick
);
  logic [7:0] cnt;
  wire logic  due = en && cnt == gap;
  // One-cycle low pulse every gap+1 cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt  <= 8'h00;
      kick <= 1'b1;
    end else begin
      cnt  <= (due || !en) ? 8'h00 : cnt + 8'h01;
      kick <= !due;
    end
  end
endmodule // wwd_mcu
`default_nettype wire

// ---- wwd_core_bench.sv ----
// Self-checking bench for the window watchdog core
`timescale 1ns/1ps
`default_nettype none
module wwd_core_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        en = 1'b0;
  logic        cap = 1'b0;
  logic [1:0]  straps = 2'h0;
  logic [1:0]  dsel = 2'h0;
  logic [7:0]  gap = 8'h00;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;
  logic        err;
  wire logic [31:0] prdata;
  wire logic   pready, pslverr, kick, fault_out_n, fault_out_oe, irq;
  int          failures = 0;
  int          checks = 0;
  int          n;
  always #12.5 pclk = ~pclk;
  wwd_core #(.TICK_CYCLES(4), .LOW_00(16'h0004), .UP_00(16'h0008), .LOW_11(16'h0006),
    .UP_11(16'h000C)) wwd_core_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .kick_input(kick), .window_cap_pin(cap), .window_strap_a(straps[0]),
    .window_strap_b(straps[1]), .delay_select_pin(dsel), .fault_pin_in(!fault_out_oe),
    .fault_out_n, .fault_out_oe, .irq);
  wwd_mcu wwd_mcu_i (.pclk, .presetn, .en, .gap, .kick);
  ////////////////////////////////////////
  task automatic end_sim;
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    chk(32'(k < 20), 32'h1);
    if (k >= 20) end_sim;
  endtask
  task automatic run(input int c);
    n = 0;
    repeat (c) begin
      @(posedge pclk);
      if (fault_out_n !== 1'b1) n++;
    end
  endtask
  task automatic wait_lvl(input logic v);
    n = 0;
    while (fault_out_n !== v && n < 9000) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n < 9000), 32'h1);
    if (n >= 9000) end_sim;
  endtask
  task automatic start(input logic [1:0] s, input logic [1:0] d, input logic e, input int g);
    presetn <= 1'b0;
    straps <= s;
    dsel <= d;
    en <= e;
    gap <= 8'(g);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  ////////////////////////////////////////
  initial begin
    @(posedge pclk);
    start(2'h0, 2'h0, 1'b0, 24);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, 32'h0000_3E80);
    apb(1'b0, 12'h020, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, 12'h008, 32'hFFFF_FFFF);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h7);
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    chk(32'(n >= 7996 && n <= 8008), 32'h1);
    chk(32'(irq), 32'h1);
    @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h5);
    chk(32'(irq), 32'h0);
    start(2'h0, 2'h0, 1'b1, 24);
    run(200);
    chk(n, 0);
    start(2'h0, 2'h0, 1'b1, 8);
    wait_lvl(1'b0);
    apb(1'b0, 12'h004, 32'h0);
    chk(32'(rd[1]), 32'h1);
    start(2'h3, 2'h0, 1'b1, 36);
    run(300);
    chk(n, 0);
    start(2'h0, 2'h0, 1'b1, 36);
    wait_lvl(1'b0);
    start(2'h1, 2'h0, 1'b0, 0);
    run(200);
    chk(n, 0);
    start(2'h0, 2'h1, 1'b0, 0);
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    chk(32'(n >= 396 && n <= 408), 32'h1);
    start(2'h0, 2'h3, 1'b0, 0);
    wait_lvl(1'b0);
    run(200);
    chk(n, 200);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0000_0007);
    cap <= 1'b1;
    start(2'h0, 2'h2, 1'b0, 0);
    @(posedge pclk);
    chk(32'(fault_out_n), 32'h1);
    apb(1'b1, 12'h00C, 32'h0000_000A);
    apb(1'b1, 12'h010, 32'h0000_0005);
    wait_lvl(1'b0);
    chk(32'(n >= 30 && n <= 40), 32'h1);
    wait_lvl(1'b1);
    chk(32'(n >= 18 && n <= 25), 32'h1);
    end_sim;
  end
endmodule // wwd_core_bench
`default_nettype wire
